//--- wdt_pkg.sv
// ****************************************************************
// shared constants for the watchdog timer
// ****************************************************************
package wdt_pkg;

   // ****************************************************************
   // register byte addresses
   // ****************************************************************
   localparam logic [31:0] WDT_ADDR_RELOAD = 32'hffff_0360;
   localparam logic [31:0] WDT_ADDR_COUNT = 32'hffff_0364;
   localparam logic [31:0] WDT_ADDR_CONTROL = 32'hffff_0368;
   localparam logic [31:0] WDT_ADDR_CLEAR = 32'hffff_036c;
   localparam logic [31:0] WDT_ADDR_CAPTURE = 32'hffff_0370;

   // ****************************************************************
   // values after reset
   // ****************************************************************
   localparam logic [15:0] WDT_RELOAD_RST = 16'h03d7;
   localparam logic [15:0] WDT_COUNT_RST = 16'h03d7;
   localparam logic [15:0] WDT_CAPTURE_RST = 16'h0000;
   localparam logic [8:0] WDT_CTRL_RST = 9'h000;
   localparam logic [7:0] WDT_LFSR_RST = 8'h00;
   localparam logic [7:0] WDT_PRE_RST = 8'h00;

   // ****************************************************************
   // control field positions
   // ****************************************************************
   localparam int WDT_CTRL_W = 9;
   localparam int WDT_BIT_STOP_PD = 0;
   localparam int WDT_BIT_IRQ_SEL = 1;
   localparam int WDT_BIT_PRE_LO = 2;
   localparam int WDT_BIT_PRE_HI = 3;
   localparam int WDT_BIT_SECURE = 4;
   localparam int WDT_BIT_WD_MODE = 5;
   localparam int WDT_BIT_PERIODIC = 6;
   localparam int WDT_BIT_ENABLE = 7;
   localparam int WDT_BIT_COUNT_UP = 8;

   // ****************************************************************
   // counting constants
   // ****************************************************************
   localparam logic [15:0] WDT_COUNT_ZERO = 16'h0000;
   localparam logic [15:0] WDT_COUNT_FULL = 16'hffff;
   localparam logic [15:0] WDT_COUNT_ONE = 16'h0001;
   localparam logic [7:0] WDT_LFSR_TAPS = 8'h63;
   localparam logic [7:0] WDT_PRE_MASK16 = 8'h0f;
   localparam logic [7:0] WDT_PRE_MASK256 = 8'hff;
   localparam int WDT_OSC_HZ = 32768;
   localparam int WDT_MAX_TIMEOUT_S = 512;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {WDT_PRE_DIV1, WDT_PRE_DIV16, WDT_PRE_DIV256, WDT_PRE_RSVD}
      wdt_pre_type;
   typedef enum logic {WDT_MODE_NORMAL, WDT_MODE_WATCHDOG} wdt_mode_type;

   // address match for one register word
   function automatic logic wdt_hit(input logic [31:0] addr, input logic [31:0] base);
      wdt_hit = (addr == base);
   endfunction

endpackage

//--- wdt_prescaler.sv
`timescale 1ns/1ps
// ****************************************************************
// oscillator prescaler, divide by 1, 16 or 256
// ****************************************************************
module wdt_prescaler (
   input logic clk_sys,
   input logic reset,
   input logic osc_rise,
   input logic run,
   input wdt_pkg::wdt_pre_type sel,
   output logic tick
);
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic last_w;

   // terminal count per division setting
   assign last_w = (sel == wdt_pkg::WDT_PRE_DIV16) ?
                   ((div_q & wdt_pkg::WDT_PRE_MASK16) == wdt_pkg::WDT_PRE_MASK16) :
                   (sel == wdt_pkg::WDT_PRE_DIV256) ? (div_q == wdt_pkg::WDT_PRE_MASK256) :
                   1'b1;
   assign tick = run && osc_rise && last_w;
   assign div_d = (run && osc_rise) ? div_q + 8'h01 : div_q;

   // divider counter
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
         div_q <= wdt_pkg::WDT_PRE_RST;
      else
         div_q <= div_d;
   end
endmodule

//--- wdt_lfsr.sv
`timescale 1ns/1ps
// ****************************************************************
// secure clear sequence register
// ****************************************************************
module wdt_lfsr (
   input logic clk_sys,
   input logic reset,
   input logic load,
   input logic advance,
   input logic [7:0] seed,
   output logic [7:0] state
);
   logic [7:0] state_q;
   logic [7:0] next_w;

   // galois step, taps x8+x6+x5+x+1
   assign next_w = {state_q[6:0], 1'b0} ^ (state_q[7] ? wdt_pkg::WDT_LFSR_TAPS : 8'h00);
   assign state = state_q;

   // seed load or step
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
         state_q <= wdt_pkg::WDT_LFSR_RST;
      else if (load)
         state_q <= seed;
      else if (advance)
         state_q <= next_w;
   end
endmodule

//--- wdt_timer.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module wdt_timer (
   input logic clk_sys,
   input logic reset,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input logic osc_32k,
   input logic debug_halt,
   input logic periph_powerdown,
   input logic capture_enable,
   output logic wdog_reset_req,
   output logic wdog_irq,
   output logic timer_irq
);
   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [15:0] reload_q;
   logic [15:0] reload_d;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [15:0] capture_q;
   logic [15:0] capture_d;
   logic [8:0] ctrl_q;
   logic [8:0] ctrl_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic osc_q;
   logic timer_irq_q;
   logic timer_irq_d;
   logic wdog_irq_q;
   logic wdog_irq_d;
   logic rst_req_q;
   logic rst_req_d;
   logic hit_reload;
   logic hit_count;
   logic hit_ctrl;
   logic hit_clear;
   logic hit_capture;
   logic hit_any;
   logic setup_w;
   logic wr_w;
   logic clr_wr;
   logic locked_w;
   logic wd_w;
   logic run_w;
   logic tick_w;
   logic up_w;
   logic at_end_w;
   logic event_w;
   logic timeout_w;
   logic secure_w;
   logic sec_check_w;
   logic sec_miss_w;
   logic sec_match_w;
   logic [7:0] lfsr_w;
   logic [15:0] step_w;
   wdt_pkg::wdt_mode_type mode_w;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   // register selection and apb phases
   assign hit_reload = wdt_pkg::wdt_hit(paddr, wdt_pkg::WDT_ADDR_RELOAD);
   assign hit_count = wdt_pkg::wdt_hit(paddr, wdt_pkg::WDT_ADDR_COUNT);
   assign hit_ctrl = wdt_pkg::wdt_hit(paddr, wdt_pkg::WDT_ADDR_CONTROL);
   assign hit_clear = wdt_pkg::wdt_hit(paddr, wdt_pkg::WDT_ADDR_CLEAR);
   assign hit_capture = wdt_pkg::wdt_hit(paddr, wdt_pkg::WDT_ADDR_CAPTURE);
   assign hit_any = hit_reload | hit_count | hit_ctrl | hit_clear | hit_capture;
   assign setup_w = psel && !penable;
   assign wr_w = psel && penable && pwrite && hit_any;
   assign clr_wr = wr_w && hit_clear;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !hit_any;
   assign prdata = prdata_q;

   // read data latched in the setup cycle, reserved bits zero
   assign prdata_d = !setup_w ? prdata_q :
                     hit_reload ? {16'h0000, reload_q} :
                     hit_count ? {16'h0000, count_q} :
                     hit_ctrl ? {23'h00_0000, ctrl_q} :
                     hit_capture ? {16'h0000, capture_q} :
                     32'h0000_0000;

   // ****************************************************************
   // mode and protection
   // ****************************************************************
   // watchdog entry locks reload and control
   assign wd_w = ctrl_q[wdt_pkg::WDT_BIT_WD_MODE];
   assign mode_w = wd_w ? wdt_pkg::WDT_MODE_WATCHDOG : wdt_pkg::WDT_MODE_NORMAL;
   assign locked_w = wd_w;
   assign reload_d = (wr_w && hit_reload && !locked_w) ? pwdata[15:0] : reload_q;
   assign ctrl_d = (wr_w && hit_ctrl && !locked_w) ? pwdata[8:0] : ctrl_q;

   // ****************************************************************
   // counting
   // ****************************************************************
   // halt in debug, optional halt in power-down
   assign run_w = (ctrl_q[wdt_pkg::WDT_BIT_ENABLE] || wd_w) && !debug_halt &&
                  !(ctrl_q[wdt_pkg::WDT_BIT_STOP_PD] && periph_powerdown);

   wdt_prescaler u_prescaler (
      .clk_sys(clk_sys),
      .reset(reset),
      .osc_rise(osc_32k && !osc_q),
      .run(run_w),
      .sel(wdt_pkg::wdt_pre_type'(ctrl_q[wdt_pkg::WDT_BIT_PRE_HI:wdt_pkg::WDT_BIT_PRE_LO])),
      .tick(tick_w)
   );

   // direction, end of range and step value
   assign up_w = ctrl_q[wdt_pkg::WDT_BIT_COUNT_UP] && !wd_w;
   assign at_end_w = up_w ? (count_q == wdt_pkg::WDT_COUNT_FULL) :
                     (count_q == wdt_pkg::WDT_COUNT_ZERO);
   assign event_w = tick_w && at_end_w;
   assign timeout_w = event_w && wd_w;
   assign step_w = up_w ? count_q + wdt_pkg::WDT_COUNT_ONE : count_q - wdt_pkg::WDT_COUNT_ONE;

   // secure clear check against the sequence register
   assign secure_w = ctrl_q[wdt_pkg::WDT_BIT_SECURE];
   assign sec_check_w = clr_wr && wd_w && secure_w;
   assign sec_miss_w = sec_check_w && ((pwdata[7:0] != lfsr_w) ||
                       (lfsr_w == 8'h00));
   assign sec_match_w = sec_check_w && !sec_miss_w;

   wdt_lfsr u_lfsr (
      .clk_sys(clk_sys),
      .reset(reset),
      .load(clr_wr && !wd_w),
      .advance(sec_match_w),
      .seed(pwdata[7:0]),
      .state(lfsr_w)
   );

   // next count value
   always_comb
   begin
      count_d = count_q;
      case (mode_w)
         wdt_pkg::WDT_MODE_WATCHDOG:
         begin
            if (clr_wr || timeout_w)
               count_d = reload_q;
            else if (tick_w)
               count_d = step_w;
         end
         wdt_pkg::WDT_MODE_NORMAL:
         begin
            if (clr_wr || (event_w && ctrl_q[wdt_pkg::WDT_BIT_PERIODIC]))
               count_d = reload_q;
            else if (tick_w)
               count_d = step_w;
         end
         default:
            count_d = count_q;
      endcase
   end

   // ****************************************************************
   // events and capture
   // ****************************************************************
   // set wins over clear on both irq flags; the reset request is a one-cycle pulse
   assign timer_irq_d = (event_w && !wd_w) || (timer_irq_q && !clr_wr);
   assign wdog_irq_d = (timeout_w && ctrl_q[wdt_pkg::WDT_BIT_IRQ_SEL]) ||
                       (wdog_irq_q && !clr_wr);
   assign rst_req_d = (timeout_w && !ctrl_q[wdt_pkg::WDT_BIT_IRQ_SEL]) ||
                      sec_miss_w;
   assign capture_d = (capture_enable && !wd_w) ? count_q : capture_q;
   assign timer_irq = timer_irq_q;
   assign wdog_irq = wdog_irq_q;
   assign wdog_reset_req = rst_req_q;

   // ****************************************************************
   // registers, cleared only by power-on reset
   // ****************************************************************
   // config registers
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         reload_q <= wdt_pkg::WDT_RELOAD_RST;
         ctrl_q <= wdt_pkg::WDT_CTRL_RST;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         reload_q <= reload_d;
         ctrl_q <= ctrl_d;
         prdata_q <= prdata_d;
      end
   end

   // counter state, untouched by system resets
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         count_q <= wdt_pkg::WDT_COUNT_RST;
         capture_q <= wdt_pkg::WDT_CAPTURE_RST;
         osc_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         capture_q <= capture_d;
         osc_q <= osc_32k;
      end
   end

   // event flags
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         timer_irq_q <= 1'b0;
         wdog_irq_q <= 1'b0;
         rst_req_q <= 1'b0;
      end
      else
      begin
         timer_irq_q <= timer_irq_d;
         wdog_irq_q <= wdog_irq_d;
         rst_req_q <= rst_req_d;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_locked_write(logic hit);
      locked_w && wr_w && hit;
   endsequence

   sequence s_plain_service;
      clr_wr && !sec_check_w;
   endsequence

   chk_lock_reload: assert property (
      @(posedge clk_sys) disable iff (reset)
      s_locked_write(hit_reload) |=> $stable(reload_q))
      else $error("reload changed while locked");

   chk_lock_control: assert property (
      @(posedge clk_sys) disable iff (reset)
      s_locked_write(hit_ctrl) |=> $stable(ctrl_q))
      else $error("control changed while locked");

   chk_service_reload: assert property (
      @(posedge clk_sys) disable iff (reset)
      s_plain_service |=> (count_q == $past(reload_q)) && !rst_req_q)
      else $error("service write did not reload");

   chk_wd_irq_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      wdog_irq_q && !clr_wr |=> wdog_irq_q)
      else $error("watchdog irq dropped early");

   chk_timeout_reset: assert property (
      @(posedge clk_sys) disable iff (reset)
      wd_w && tick_w && (count_q == 16'h0000) && !ctrl_q[1]
      |=> rst_req_q ##1 (!rst_req_q || $past(sec_miss_w)))
      else $error("timeout reset missing");

   chk_timeout_irq: assert property (
      @(posedge clk_sys) disable iff (reset)
      wd_w && tick_w && (count_q == 16'h0000) && ctrl_q[1] && !sec_miss_w
      |=> wdog_irq_q && !rst_req_q)
      else $error("timeout irq missing");

   chk_debug_halt: assert property (
      @(posedge clk_sys) disable iff (reset)
      debug_halt && !clr_wr |=> $stable(count_q))
      else $error("count moved in debug halt");

   chk_pd_stop: assert property (
      @(posedge clk_sys) disable iff (reset)
      ctrl_q[0] && periph_powerdown && !clr_wr |=> $stable(count_q))
      else $error("count moved in power-down");

   chk_wd_down: assert property (
      @(posedge clk_sys) disable iff (reset)
      wd_w && tick_w && !clr_wr && (count_q != 16'h0000)
      |=> count_q == $past(count_q) - 16'h0001)
      else $error("watchdog did not decrement");

   chk_secure_miss: assert property (
      @(posedge clk_sys) disable iff (reset)
      sec_check_w && (pwdata[7:0] != lfsr_w) |=> rst_req_q)
      else $error("secure mismatch without reset");

   chk_normal_clear: assert property (
      @(posedge clk_sys) disable iff (reset)
      clr_wr && !(tick_w && at_end_w) |=> !timer_irq_q)
      else $error("clear did not drop timer irq");

   chk_up_step: assert property (
      @(posedge clk_sys) disable iff (reset)
      up_w && tick_w && !clr_wr && !at_end_w
      |=> count_q == $past(count_q) + 16'h0001)
      else $error("up count did not increment");

   chk_periodic_end: assert property (
      @(posedge clk_sys) disable iff (reset)
      event_w && !wd_w && ctrl_q[wdt_pkg::WDT_BIT_PERIODIC]
      |=> timer_irq_q && (count_q == $past(reload_q)))
      else $error("periodic end missed");

   chk_capture_track: assert property (
      @(posedge clk_sys) disable iff (reset)
      capture_enable && !wd_w |=> capture_q == $past(count_q))
      else $error("capture did not follow count");

   chk_secure_match: assert property (
      @(posedge clk_sys) disable iff (reset)
      sec_match_w && !timeout_w
      |=> !rst_req_q && (count_q == $past(reload_q)) && (lfsr_w != $past(lfsr_w)))
      else $error("secure match did not reload and step");

endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic osc_32k = 1'b0;
   logic debug_halt = 1'b0;
   logic periph_powerdown = 1'b0;
   logic capture_enable = 1'b0;
   logic wdog_reset_req;
   logic wdog_irq;
   logic timer_irq;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_pulse = 0;
   logic [31:0] rd;
   logic err;

   // ****************************************************************
   // clock, design and reset request counter
   // ****************************************************************
   always #50 clk_sys = ~clk_sys;

   wdt_timer wdt_timer_inst (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_32k(osc_32k),
      .debug_halt(debug_halt), .periph_powerdown(periph_powerdown),
      .capture_enable(capture_enable), .wdog_reset_req(wdog_reset_req),
      .wdog_irq(wdog_irq), .timer_irq(timer_irq));

   // counts reset request pulses seen
   always @(posedge clk_sys)
      if (wdog_reset_req === 1'b1)
         n_pulse <= n_pulse + 1;

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic test_done;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         n_mismatch++;
         $display("BAD pready expected 1 seen timeout");
         test_done();
      end
      else
      begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(nm, rd, exp);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // n oscillator rising edges, then settle
   task automatic osc(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         osc_32k <= 1'b1;
         @(posedge clk_sys);
         osc_32k <= 1'b0;
         @(posedge clk_sys);
      end
      wait_cyc(3);
   endtask

   task automatic do_reset;
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs;
      do_reset();
      rdchk("reload", wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_03d7);
      rdchk("count", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_03d7);
      rdchk("control", wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_0000);
      rdchk("clear", wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      apb(1'b0, 32'hffff_0374, 32'h0000_0000);
      check("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
      wr(wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_abcd);
      rdchk("reload rw", wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_abcd);
      wr(wdt_pkg::WDT_ADDR_COUNT, 32'h0000_1111);
      rdchk("count ro", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_03d7);
      $display("test regs done");
   endtask

   task automatic t_normal;
      do_reset();
      wr(wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_0003);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_00c0);
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      rdchk("count load", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0003);
      osc(3);
      rdchk("count zero", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0000);
      check("irq early", {31'h0000_0000, timer_irq}, 32'h0000_0000);
      osc(1);
      check("irq set", {31'h0000_0000, timer_irq}, 32'h0000_0001);
      rdchk("periodic", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0003);
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_005a);
      wait_cyc(2);
      check("irq clear", {31'h0000_0000, timer_irq}, 32'h0000_0000);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_0080);
      osc(4);
      rdchk("free run", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_ffff);
      $display("test normal done");
   endtask

   task automatic t_dir_halt;
      do_reset();
      wr(wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_0010);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_0180);
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      osc(2);
      rdchk("up", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0012);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_0100);
      osc(2);
      rdchk("disabled", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0012);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_00c0);
      debug_halt <= 1'b1;
      osc(2);
      rdchk("debug", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0012);
      debug_halt <= 1'b0;
      periph_powerdown <= 1'b1;
      osc(1);
      rdchk("pd run", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0011);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_00c1);
      osc(2);
      rdchk("pd stop", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0011);
      periph_powerdown <= 1'b0;
      capture_enable <= 1'b1;
      osc(1);
      rdchk("capture", wdt_pkg::WDT_ADDR_CAPTURE, 32'h0000_0010);
      capture_enable <= 1'b0;
      osc(2);
      rdchk("capture held", wdt_pkg::WDT_ADDR_CAPTURE, 32'h0000_0010);
      $display("test direction and halt done");
   endtask

   task automatic t_prescale;
      for (int c = 1; c < 3; c++)
      begin
         do_reset();
         wr(wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_000a);
         wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_00c0 | (c << 2));
         wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
         osc((c == 1) ? 15 : 255);
         rdchk("pre hold", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_000a);
         osc(1);
         rdchk("pre tick", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0009);
      end
      $display("test prescale done");
   endtask

   task automatic t_wd(input logic irq_opt);
      int p0;
      do_reset();
      wr(wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_0002);
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      wr(wdt_pkg::WDT_ADDR_CONTROL, irq_opt ? 32'h0000_0022 : 32'h0000_0020);
      p0 = n_pulse;
      osc(2);
      rdchk("wd zero", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0000);
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      osc(2);
      check("serviced", 32'(n_pulse - p0), 32'h0000_0000);
      osc(1);
      check("timeout req", 32'(n_pulse - p0), irq_opt ? 32'h0000_0000 : 32'h0000_0001);
      check("timeout irq", {31'h0000_0000, wdog_irq}, {31'h0000_0000, irq_opt});
      rdchk("wd reload", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0002);
      wr(wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_1234);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_0000);
      rdchk("lock reload", wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_0002);
      rdchk("lock control", wdt_pkg::WDT_ADDR_CONTROL, {24'h0000_00, 6'h08, irq_opt, 1'b0});
      check("irq held", {31'h0000_0000, wdog_irq}, {31'h0000_0000, irq_opt});
      osc(1);
      rdchk("keeps count", wdt_pkg::WDT_ADDR_COUNT, 32'h0000_0001);
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      wait_cyc(2);
      check("irq cleared", {31'h0000_0000, wdog_irq}, 32'h0000_0000);
      $display("test watchdog done");
   endtask

   task automatic t_secure;
      logic [7:0] seq [3] = '{8'haa, 8'h37, 8'h6e};
      int p0;
      do_reset();
      wr(wdt_pkg::WDT_ADDR_RELOAD, 32'h0000_0100);
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_00aa);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_0030);
      p0 = n_pulse;
      foreach (seq[i])
         wr(wdt_pkg::WDT_ADDR_CLEAR, {24'h0000_00, seq[i]});
      wait_cyc(3);
      check("seq match", 32'(n_pulse - p0), 32'h0000_0000);
      rdchk("lfsr hidden", wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0066);
      wait_cyc(3);
      check("seq miss", 32'(n_pulse - p0), 32'h0000_0001);
      do_reset();
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      wr(wdt_pkg::WDT_ADDR_CONTROL, 32'h0000_0030);
      p0 = n_pulse;
      wr(wdt_pkg::WDT_ADDR_CLEAR, 32'h0000_0000);
      wait_cyc(3);
      check("zero seed", 32'(n_pulse - p0), 32'h0000_0001);
      $display("test secure done");
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      t_regs();
      t_normal();
      t_dir_halt();
      t_prescale();
      t_wd(1'b0);
      t_wd(1'b1);
      t_secure();
      test_done();
   end
endmodule
